// ---- pkg/vbi_framer_defs.svh ----
/*
 * Constants of the ancillary packet framer: word values, word positions,
 * data count codes, raw byte counts and the location of the format select bit.
 * Assumes it is included by its bare name and defines nothing else.
 */
`ifndef VBI_FRAMER_DEFS_SVH
`define VBI_FRAMER_DEFS_SVH

// ----------------------------------------------------------------------
// Fixed packet words
// ----------------------------------------------------------------------
`define PREAMBLE_LO      10'h000
`define PREAMBLE_HI      10'h3ff
`define DID_WORD         10'h140
`define PAD_WORD         10'h200

// ----------------------------------------------------------------------
// Word positions inside a packet
// ----------------------------------------------------------------------
`define IDX_DID          4'h3
`define IDX_SDID         4'h4
`define IDX_COUNT        4'h5
`define IDX_FIRST_UDW    4'h6
`define IDX_LAST_LONG    4'he
`define IDX_LAST_SHORT   4'ha

// ----------------------------------------------------------------------
// Data count codes and raw byte counts
// ----------------------------------------------------------------------
`define COUNT_EIGHT_UDW  2'h2
`define COUNT_FOUR_UDW   2'h1
`define BYTES_DOUBLE     4'h4
`define BYTES_SINGLE     4'h2

// ----------------------------------------------------------------------
// Format select location in the decoder's configuration space
// ----------------------------------------------------------------------
`define FMT_SEL_OFFSET   8'h4c
`define FMT_SEL_BIT      0

`endif

// ---- pkg/vbi_framer_pkg.sv ----
/*
 * Types of the ancillary packet framer.
 * Assumes nothing of its surroundings.
 */
package vbi_framer_pkg;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef logic [3:0] line_code_type;      // Source line code
    typedef enum logic {IDLE, SEND} fsm_type; // Framer sequencer

endpackage : vbi_framer_pkg

// ---- rtl/vbi_ancillary_packet_framer.sv ----
/*
 * Ancillary packet framer: formats bytes recovered by the line slicer
 * into packets and inserts them into the blanking of a 10-bit stream.
 * Assumes the stream, the end-of-active-video strobe and the slicer
 * outputs all come from logic on clk, so no input is synchronised.
 */
// Functional notes
// - Format bit 0: bytes split into nibbles
// - Format bit 1: each byte one whole word
// - Format bit is configuration bit 0 at 0x4C
// - Double half-byte: 15 words, count 2, nibbles
// - Double full-byte: 11 words, count 1, bytes
// - Single half-byte: count 1, four nibble words
// - Single full-byte: two bytes, two 200h pads
// - Preamble 000,3FF,3FF then identifier 140h
// - Header, nibble words: even parity, inverse above
// - Checksum sums D[8:2] from identifier onward
// - Packet starts right after end-of-active-video
`timescale 1ns/1ns
`default_nettype none
`include "vbi_framer_defs.svh"

module vbi_ancillary_packet_framer (
    input  wire logic                          clk,                 // 10 MHz clock
    input  wire logic                          rst_b,               // Sync reset, low
    input  wire logic [9:0]                    video_in,            // Stream from timing
    input  wire logic                          eav_done,            // Last end code word
    input  wire logic                          ancillary_byte_format_sel, // Byte format
    input  wire logic                          slice_valid,         // Slicer has data
    input  wire logic                          line_decode_en,      // Line is enabled
    input  wire logic [31:0]                   slice_data,          // Bytes, first low
    input  wire logic                          double_rate_flag,    // Four bytes sliced
    input  wire logic                          even_field_flag,     // From even field
    input  wire vbi_framer_pkg::line_code_type slice_line,          // Source line code
    output var  logic [9:0]                    video_out,           // Stream with packets
    output var  logic                          anc_active           // Packet word on out
);
    import vbi_framer_pkg::*;

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        fsm_type       st;        // Sequencer
        logic          pend;      // Packet waiting for next line
        logic [31:0]   lat_data;  // Waiting bytes
        logic          lat_ef;    // Waiting field flag
        logic          lat_dr;    // Waiting rate flag
        line_code_type lat_line;  // Waiting line code
        logic [31:0]   data;      // Bytes in flight
        logic          ef;        // Field flag in flight
        logic          dr;        // Rate flag in flight
        logic          fmt;       // Format in flight
        line_code_type line;      // Line code in flight
        logic [3:0]    idx;       // Word being built
        logic [6:0]    cs;        // Running checksum
        logic [9:0]    vid;       // Output word
        logic          act;       // Output word is a packet word
        logic [3:0]    oidx;      // Index of the output word
    } framer_state_type;

    framer_state_type s_q;        // Registered state
    framer_state_type s_d;        // Next state
    logic             start_pkt;  // Packet begins this cycle
    logic [9:0]       word;       // Word built this cycle

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Parity pair on top of an 8-bit payload
    function automatic logic [9:0] with_parity(input logic [7:0] d);
        logic ep;
        ep = ^d;
        return {~ep, ep, d};
    endfunction : with_parity

    // Index of the checksum word for a layout
    function automatic logic [3:0] last_idx(input logic dr, input logic fmt);
        return (dr && !fmt) ? `IDX_LAST_LONG : `IDX_LAST_SHORT;
    endfunction : last_idx

    // Word at a position of the packet
    function automatic logic [9:0] word_at(
        input logic [3:0]    idx,
        input logic [31:0]   data,
        input logic          ef,
        input logic          dr,
        input logic          fmt,
        input line_code_type line,
        input logic [6:0]    cs
    );
        logic [3:0] k;
        logic [1:0] sel;
        logic [7:0] b;
        logic [3:0] nib;
        logic [1:0] dc;
        k   = idx - `IDX_FIRST_UDW;
        sel = fmt ? k[1:0] : k[2:1];
        b   = 8'(data >> {sel, 3'h0});
        nib = k[0] ? b[3:0] : b[7:4];
        dc  = (dr && !fmt) ? `COUNT_EIGHT_UDW : `COUNT_FOUR_UDW;
        if (idx == 4'h0) begin
            word_at = `PREAMBLE_LO;
        end else if (idx < `IDX_DID) begin
            word_at = `PREAMBLE_HI;
        end else if (idx == `IDX_DID) begin
            word_at = `DID_WORD;
        end else if (idx == `IDX_SDID) begin
            word_at = with_parity({ef, dr, line, 2'h0});
        end else if (idx == `IDX_COUNT) begin
            word_at = with_parity({4'h0, dc, 2'h0});
        end else if (idx == last_idx(dr, fmt)) begin
            word_at = {~cs[6], cs, 2'h0};
        end else if (!fmt) begin
            word_at = with_parity({2'h0, nib, 2'h0});
        end else if (k < (dr ? `BYTES_DOUBLE : `BYTES_SINGLE)) begin
            word_at = {b, 2'h0};
        end else begin
            word_at = `PAD_WORD;
        end
    endfunction : word_at

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Start only with a packet waiting and nothing in flight
    assign start_pkt = eav_done && s_q.pend && (s_q.st == IDLE);

    assign word = word_at(s_q.idx, s_q.data, s_q.ef, s_q.dr, s_q.fmt, s_q.line, s_q.cs);

    // Sequencer, capture and output word
    always_comb begin
        s_d = s_q;
        // Launch the waiting packet
        if (start_pkt) begin
            s_d.st   = SEND;
            s_d.pend = 1'b0;
            s_d.data = s_q.lat_data;
            s_d.ef   = s_q.lat_ef;
            s_d.dr   = s_q.lat_dr;
            s_d.line = s_q.lat_line;
            s_d.fmt  = ancillary_byte_format_sel;
            s_d.idx  = 4'h0;
            s_d.cs   = 7'h00;
        end
        // Capture after launch so that fresh data is never lost
        if (slice_valid && line_decode_en) begin
            s_d.pend     = 1'b1;
            s_d.lat_data = slice_data;
            s_d.lat_ef   = even_field_flag;
            s_d.lat_dr   = double_rate_flag;
            s_d.lat_line = slice_line;
        end
        unique case (s_q.st)
            IDLE: begin
                // Blanking passes through untouched
                s_d.vid = video_in;
                s_d.act = 1'b0;
            end
            SEND: begin
                // Packet word replaces the stream word
                s_d.vid  = word;
                s_d.act  = 1'b1;
                s_d.oidx = s_q.idx;
                s_d.idx  = s_q.idx + 4'h1;
                if ((s_q.idx >= `IDX_DID) && (s_q.idx < last_idx(s_q.dr, s_q.fmt))) begin
                    s_d.cs = s_q.cs + word[8:2];
                end
                if (s_q.idx == last_idx(s_q.dr, s_q.fmt)) begin
                    s_d.st = IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign video_out  = s_q.vid;
    assign anc_active = s_q.act;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [6:0] chk_sum; // Sum of output words seen so far
    logic [3:0] o_last;  // Checksum index of current packet

    assign o_last = last_idx(s_q.dr, s_q.fmt);

    // Independent checksum of what actually left the block
    always_ff @(posedge clk) begin
        if (!rst_b || start_pkt) begin
            chk_sum <= 7'h00;
        end else if (s_q.act && (s_q.oidx >= `IDX_DID) && (s_q.oidx < o_last)) begin
            chk_sum <= chk_sum + video_out[8:2];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence preamble_s;
        video_out == `PREAMBLE_LO ##1 video_out == `PREAMBLE_HI
            ##1 video_out == `PREAMBLE_HI ##1 video_out == `DID_WORD;
    endsequence

    sequence header_ok_s;
        (^video_out[8:0] == 1'b0) && (video_out[9] != video_out[8]);
    endsequence

    a_nibble_words: assert property (s_q.act && !s_q.fmt && s_q.oidx >= `IDX_FIRST_UDW
        && s_q.oidx < o_last |-> header_ok_s and (video_out[7:6] == 2'h0))
        else $error("Nibble word malformed");
    a_full_bytes: assert property (s_q.act && s_q.fmt && s_q.oidx == `IDX_FIRST_UDW
        |-> video_out == {s_q.data[7:0], 2'h0})
        else $error("Full byte word wrong");
    a_format_take: assert property (start_pkt
        |=> s_q.fmt == $past(ancillary_byte_format_sel))
        else $error("Format not taken at start");
    a_long_packet: assert property (start_pkt && s_q.lat_dr && !ancillary_byte_format_sel
        |-> ##16 (anc_active && s_q.oidx == `IDX_LAST_LONG) ##1 !anc_active)
        else $error("Double half packet length wrong");
    a_short_double: assert property (start_pkt && s_q.lat_dr && ancillary_byte_format_sel
        |-> ##12 anc_active ##1 !anc_active)
        else $error("Double full packet length wrong");
    a_single_count: assert property (s_q.act && !s_q.dr && s_q.oidx == `IDX_COUNT
        |-> video_out[7:2] == 6'h01 ##5 s_q.oidx == `IDX_LAST_SHORT)
        else $error("Single rate count wrong");
    a_pad_words: assert property (s_q.act && !s_q.dr && s_q.fmt
        && (s_q.oidx == 4'h8 || s_q.oidx == 4'h9) |-> video_out == `PAD_WORD)
        else $error("Padding word wrong");
    a_preamble_did: assert property (start_pkt |-> ##2 preamble_s)
        else $error("Preamble or identifier wrong");
    a_header_parity: assert property (s_q.act
        && (s_q.oidx == `IDX_SDID || s_q.oidx == `IDX_COUNT) |-> header_ok_s)
        else $error("Header parity wrong");
    a_checksum_word: assert property (s_q.act && s_q.oidx == o_last
        |-> video_out[8:2] == chk_sum && video_out[9] == !video_out[8])
        else $error("Checksum mismatch");
    a_start_timing: assert property (eav_done && s_q.pend && !s_q.act && s_q.st == IDLE
        |-> ##2 anc_active && s_q.oidx == 4'h0)
        else $error("Packet not right after end code");
    a_idle_pass: assert property (s_q.st == IDLE && !start_pkt
        |=> !anc_active && video_out == $past(video_in))
        else $error("Blanking altered without packet");

endmodule : vbi_ancillary_packet_framer
`default_nettype wire

// ---- tb/vbi_capture_model.sv ----
/*
 * Capture model of the video receiver that reads the framed stream.
 * Assumes one word per clk and anc_active marking every packet word.
 */
`timescale 1ns/1ns
`default_nettype none

module vbi_capture_model (
    input  wire logic       clk,                 // Stream clock
    input  wire logic       rst_b,               // Sync reset, low
    input  wire logic [9:0] video_out,           // Stream from framer
    input  wire logic       anc_active,          // Packet word marker
    output var  logic [9:0] cap_words [0:31],    // Last packet words
    output var  logic [4:0] cap_len,             // Last packet length
    output var  logic [7:0] cap_count            // Packets seen
);
    // ------------------------------------------------------------------
    // Packet collection
    // ------------------------------------------------------------------
    logic [4:0] idx_q;                           // Next word slot

    // Store marked words, close the packet when the marker drops
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            idx_q     <= 5'h00;
            cap_len   <= 5'h00;
            cap_count <= 8'h00;
        end else if (anc_active) begin
            cap_words[idx_q] <= video_out;
            idx_q            <= idx_q + 5'h01;
        end else if (idx_q != 5'h00) begin
            cap_len   <= idx_q;
            cap_count <= cap_count + 8'h01;
            idx_q     <= 5'h00;
        end
    end
endmodule : vbi_capture_model

`default_nettype wire

// ---- tb/testbench.sv ----
/*
 * Self-checking bench of the ancillary packet framer.
 * Assumes the framer and the capture model; inputs change on falling edges.
 */
`timescale 1ns/1ns
`default_nettype none
`include "vbi_framer_defs.svh"

module testbench;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic       clk, rst_b, eav_done, fmt_sel, slice_valid, line_decode_en;
    logic       double_rate_flag, even_field_flag, anc_active;
    logic [9:0] video_in, video_out;                // Stream in and out
    logic [31:0] slice_data;                        // Sliced bytes
    logic [3:0] slice_line;                         // Source line code
    logic [9:0] cap_words [0:31];                   // Model capture
    logic [4:0] cap_len;                            // Model length
    logic [7:0] cap_count;                          // Model packet count
    logic [9:0] exp_w [0:31];                       // Expected packet
    int         exp_len, fails, checks_done;

    vbi_ancillary_packet_framer u_vbi_ancillary_packet_framer (
        .clk(clk), .rst_b(rst_b), .video_in(video_in), .eav_done(eav_done),
        .ancillary_byte_format_sel(fmt_sel), .slice_valid(slice_valid),
        .line_decode_en(line_decode_en), .slice_data(slice_data),
        .double_rate_flag(double_rate_flag), .even_field_flag(even_field_flag),
        .slice_line(slice_line), .video_out(video_out), .anc_active(anc_active));

    vbi_capture_model u_vbi_capture_model (
        .clk(clk), .rst_b(rst_b), .video_out(video_out), .anc_active(anc_active),
        .cap_words(cap_words), .cap_len(cap_len), .cap_count(cap_count));

    // ------------------------------------------------------------------
    // Clock and moving stream
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Stream word changes every cycle so pass-through is visible
    initial begin
        video_in = 10'h000;
        forever @(negedge clk) video_in <= video_in + 10'h00d;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] expv);
        checks_done++;
        if (got !== expv) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, expv);
        end
    endtask : chk

    task automatic wrap_up();
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    // Append one word, even parity on D[8:0] and inverse on D[9] if asked
    task automatic push(input logic [9:0] w, input logic par);
        exp_w[exp_len] = par ? {~(^w[7:0]), ^w[7:0], w[7:0]} : w;
        exp_len++;
    endtask : push

    // Slicer capture; expected packet worked out alongside
    task automatic capture(input logic fm, dr, ef, input logic [3:0] ln,
                           input logic [31:0] d);
        logic [7:0] b;
        logic [6:0] cs;
        @(negedge clk);
        // Format differs at capture; only the start cycle may count
        {fmt_sel, double_rate_flag, even_field_flag} = {~fm, dr, ef};
        {slice_line, slice_data, slice_valid, line_decode_en} = {ln, d, 2'b11};
        @(negedge clk);
        slice_valid = 1'b0;
        fmt_sel = fm;
        exp_len = 0;
        push(`PREAMBLE_LO, 1'b0);
        push(`PREAMBLE_HI, 1'b0);
        push(`PREAMBLE_HI, 1'b0);
        push(10'h140, 1'b0);
        push({2'h0, ef, dr, ln, 2'h0}, 1'b1);
        push({6'h00, (dr && !fm) ? 2'h2 : 2'h1, 2'h0}, 1'b1);
        for (int i = 0; i < (dr ? 4 : 2); i++) begin
            b = d[8*i +: 8];
            if (fm) push({b, 2'h0}, 1'b0);
            else begin
                push({4'h0, b[7:4], 2'h0}, 1'b1);
                push({4'h0, b[3:0], 2'h0}, 1'b1);
            end
        end
        if (fm && !dr) repeat (2) push(10'h200, 1'b0);
        cs = 7'h00;
        for (int i = 3; i < exp_len; i++) cs = cs + exp_w[i][8:2];
        push({~cs[6], cs, 2'h0}, 1'b0);
    endtask : capture

    // Start strobe, then start timing and whole packet compared
    task automatic start_and_check();
        logic [7:0] cnt0;
        cnt0 = cap_count;
        @(negedge clk);
        eav_done = 1'b1;
        @(negedge clk);
        eav_done = 1'b0;
        fmt_sel = ~fmt_sel;
        chk(anc_active, 1'b0);
        @(negedge clk);
        chk({anc_active, video_out}, 11'h400);
        for (int k = 0; k < 40 && cap_count == cnt0; k++) @(negedge clk);
        if (cap_count == cnt0) begin
            chk(cap_count, cnt0 + 8'h01);
            wrap_up();
        end else begin
            chk(cap_len, exp_len);
            for (int i = 0; i < exp_len; i++) chk(cap_words[i], exp_w[i]);
        end
    endtask : start_and_check

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // All four layouts, boundary bytes and line codes
    task automatic scen_formats();
        capture(1'b0, 1'b1, 1'b1, 4'hf, 32'hff00_a5c3);
        start_and_check();
        capture(1'b1, 1'b1, 1'b0, 4'h0, 32'h8001_7ffe);
        start_and_check();
        capture(1'b0, 1'b0, 1'b0, 4'h9, 32'h0000_3cff);
        start_and_check();
        capture(1'b1, 1'b0, 1'b1, 4'h6, 32'h0000_ff80);
        start_and_check();
    endtask : scen_formats

    // Newer capture replaces a waiting one
    task automatic scen_overwrite();
        capture(1'b0, 1'b1, 1'b0, 4'h3, 32'h1234_5678);
        capture(1'b1, 1'b1, 1'b1, 4'hc, 32'hdead_beef);
        start_and_check();
    endtask : scen_overwrite

    // Disabled line, then no data: blanking passes unchanged
    task automatic scen_disabled();
        logic [9:0] v;
        logic [7:0] cnt0;
        cnt0 = cap_count;
        @(negedge clk);
        {slice_valid, line_decode_en} = 2'b10;
        @(negedge clk);
        {slice_valid, line_decode_en, eav_done} = 3'b011;
        @(negedge clk);
        eav_done = 1'b0;
        repeat (20) begin
            @(posedge clk);
            v = video_in;
            @(negedge clk);
            chk({anc_active, video_out}, {1'b0, v});
        end
        chk(cap_count, cnt0);
    endtask : scen_disabled

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {rst_b, eav_done, fmt_sel, slice_valid, line_decode_en} = 5'h00;
        {double_rate_flag, even_field_flag, slice_line} = 6'h00;
        slice_data = 32'h0;
        {fails, checks_done} = 64'h0;
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        chk({`FMT_SEL_OFFSET, 8'(`FMT_SEL_BIT)}, 16'h4c00);
        scen_formats();
        scen_overwrite();
        scen_disabled();
        wrap_up();
    end
endmodule : testbench

`default_nettype wire
